// file: hw/stop_clock_regs.svh
// offsets, field positions, reset values and timing figures of the clock-control block
`ifndef STOP_CLOCK_REGS_SVH
`define STOP_CLOCK_REGS_SVH

`define REG_PROC_CTL        6'h00
`define REG_LEVEL_TWO       6'h04
`define REG_LEVEL_THREE     6'h08
`define REG_COUNT_B         6'h0c
`define REG_GLOBAL_CTL      6'h10
`define REG_IDLE_CTL        6'h14
`define REG_BURST_SRC       6'h18
`define REG_STANDBY_RELOAD  6'h1c
`define REG_STATUS          6'h20
`define REG_MASK            6'h24
`define REG_CLOCK_STATE     6'h28

`define FLAG_OVERHEAT       0
`define FLAG_IDLE_LSB       1
`define FLAG_STANDBY        5
`define FLAG_BURST          6
`define FLAG_WIDTH          7

`define BURST_EXT_BIT       4
`define RESET_DUTY          3'h0
`define RESET_RELOAD        16'h0000

`define CLOCK_HZ            40000000
`define CLOCK_MHZ           40
`define OVERHEAT_DELAY_MS   2000
`define MIN_HIGH_NS         32000
`define IDLE_TICK_NS        1000

`endif

// file: hw/stop_clock_pkg.sv
// types shared by the clock-control block
package stop_clock_pkg;

	typedef enum logic [1:0] {
		FULL_SPEED,
		LEVEL_TWO,
		LEVEL_THREE
	} clk_state_t;

endpackage : stop_clock_pkg

// file: hw/halt_shaper.sv
// stop-clock output stage with a guaranteed least high time
`timescale 1ns/100ps
`include "stop_clock_regs.svh"

module halt_shaper #(
	parameter int unsigned MIN_HIGH_CYCLES = 1280
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic want_halt,
	output logic      cpu_clock_halt_n
);

	localparam int unsigned CW = $clog2(MIN_HIGH_CYCLES + 1);

	typedef struct packed {
		logic          halt_n;
		logic [CW-1:0] hold;
	} shaper_t;

	shaper_t s;
	shaper_t next_s;

	always_comb
	begin
		next_s = s;
		if (!s.halt_n)
		begin
			// R10 release holds high
			if (!want_halt)
			begin
				next_s.halt_n = 1'b1;
				next_s.hold   = CW'(MIN_HIGH_CYCLES - 1);
			end
		end
		else if (s.hold != '0)
		begin
			next_s.hold = s.hold - CW'(1);
		end
		else if (want_halt)
		begin
			next_s.halt_n = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s.halt_n <= 1'b1;
			s.hold   <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign cpu_clock_halt_n = s.halt_n;

endmodule : halt_shaper

// file: hw/stop_clock_thermal_control.sv
// processor clock-control, idle timers and thermal throttling with Avalon-MM registers
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`include "stop_clock_regs.svh"

// Behaviour
// R1: reading level-two or level-three register enters that reduced-speed clock state
// R2: expiry of an idle timer enabled as burst source raises a burst event
// R3: software keeps external bursts off and only device 3 as source on entry
// R4: activity from external disk controller cycles causes no timer reloads or events
// R5: firmware enables interrupt reloads of the standby timer during disk activity
// R6: any device idle timer timeout raises a management interrupt
// R7: thermal input with enable set and routing clear raises management interrupt
// R8: thermal input with enable and routing both set raises control interrupt
// R9: stop-clock throttling starts two seconds after thermal input asserts
// R10: stop-clock output, once released, stays high at least 32 us
// R11: duty setting seven of eight (87%) works for both duty fields
// R12: thermal input over two seconds overrides clock state; returns after it drops
// R13: thermal enable clear suppresses both thermal interrupts
// R14: thermal flag sets on thermal assertion and stays until software clears it
module stop_clock_thermal_control #(
	parameter int unsigned THERM_DELAY_CYCLES = `OVERHEAT_DELAY_MS * (`CLOCK_HZ / 1000),
	parameter int unsigned THERM_W            = 27,
	parameter int unsigned NUM_DEV            = 4
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic [5:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	input  wire logic [3:0]         byteenable,
	output logic [31:0]             readdata,
	output logic                    waitrequest,
	input  wire logic [NUM_DEV-1:0] dev_activity,
	input  wire logic               ext_disk_cycle,
	input  wire logic               irq_activity,
	input  wire logic               ext_burst,
	input  wire logic               overheat_in_n,
	output logic                    cpu_clock_halt_n,
	output logic                    mgmt_irq_n,
	output logic                    control_irq,
	output logic                    irq
);

	localparam int unsigned MIN_HIGH_CYCLES = (`MIN_HIGH_NS * `CLOCK_MHZ + 999) / 1000;
	localparam int unsigned TICK_CYCLES     = (`IDLE_TICK_NS * `CLOCK_MHZ) / 1000;
	localparam int unsigned SW              = $clog2(MIN_HIGH_CYCLES);
	localparam int unsigned TW              = $clog2(TICK_CYCLES);

	typedef struct packed {
		stop_clock_pkg::clk_state_t  cstate;
		logic                        ack;
		logic [31:0]                 readdata;
		logic [2:0]                  throttle_duty_field;
		logic                        throttle_en;
		logic [2:0]                  overheat_duty_field;
		logic                        overheat_irq_enable;
		logic                        control_irq_route_enable;
		logic                        standby_reload_on_irq;
		logic [NUM_DEV-1:0]          idle_en;
		logic [15:0]                 idle_reload;
		logic [NUM_DEV:0]            burst_source_enable;
		logic [15:0]                 standby_reload;
		logic [`FLAG_WIDTH-1:0]      flags;
		logic [`FLAG_WIDTH-1:0]      mask;
		logic [NUM_DEV-1:0][15:0]    idle_cnt;
		logic [15:0]                 standby_cnt;
		logic [TW-1:0]               tick_cnt;
		logic                        hot_q;
		logic [THERM_W-1:0]          therm_cnt;
		logic                        therm_ovr;
		logic [SW-1:0]               slot_cnt;
		logic [2:0]                  phase;
		logic                        mgmt;
		logic                        ctl_irq;
	} state_t;

	state_t s;
	state_t next_s;
	logic   want_halt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
			begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// duty counts eighths of the throttle period spent halted
	function automatic logic halted_slot(input logic [2:0] phase, input logic [2:0] duty);
		return phase < duty;
	endfunction : halted_slot

	function automatic logic [31:0] reg_value(input state_t st, input logic [5:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (addr)
			`REG_PROC_CTL:
			begin
				v[2:0] = st.throttle_duty_field;
				v[4]   = st.throttle_en;
			end
			`REG_COUNT_B:        v[2:0] = st.overheat_duty_field;
			`REG_GLOBAL_CTL:
			begin
				v[0] = st.overheat_irq_enable;
				v[1] = st.control_irq_route_enable;
				v[2] = st.standby_reload_on_irq;
			end
			`REG_IDLE_CTL:
			begin
				v[NUM_DEV-1:0] = st.idle_en;
				v[31:16]       = st.idle_reload;
			end
			`REG_BURST_SRC:      v[NUM_DEV:0] = st.burst_source_enable;
			`REG_STANDBY_RELOAD: v[15:0] = st.standby_reload;
			`REG_STATUS:         v[`FLAG_WIDTH-1:0] = st.flags;
			`REG_MASK:           v[`FLAG_WIDTH-1:0] = st.mask;
			`REG_CLOCK_STATE:
			begin
				v[1:0] = st.cstate;
				v[2]   = st.therm_ovr;
			end
			default:             v = 32'h0000_0000;
		endcase
		return v;
	endfunction : reg_value

	always_comb
	begin
		logic               req;
		logic               accept;
		logic [31:0]        wv;
		logic [NUM_DEV-1:0] act;
		logic [NUM_DEV-1:0] idle_exp;
		logic               standby_exp;
		logic               burst;
		logic               hot;
		logic               tick;
		next_s      = s;
		req         = read | write;
		accept      = req & s.ack;
		wv          = 32'h0000_0000;
		idle_exp    = '0;
		act         = '0;
		standby_exp = 1'b0;
		burst       = 1'b0;
		hot         = ~overheat_in_n;
		tick        = (s.tick_cnt == TW'(TICK_CYCLES - 1));

		// one wait state: data is captured as the answer is given
		next_s.ack = req & ~s.ack;
		if (req & ~s.ack)
		begin
			next_s.readdata = reg_value(s, address);
		end

		next_s.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);

		// R4 disk-controller cycles are not activity
		act = dev_activity & {NUM_DEV{~ext_disk_cycle}};

		for (int i = 0; i < NUM_DEV; i++)
		begin
			if (!s.idle_en[i])
			begin
				next_s.idle_cnt[i] = 16'h0000;
			end
			else if (act[i])
			begin
				next_s.idle_cnt[i] = s.idle_reload;
			end
			else if (tick && s.idle_cnt[i] != 16'h0000)
			begin
				next_s.idle_cnt[i] = s.idle_cnt[i] - 16'h0001;
				idle_exp[i]        = (s.idle_cnt[i] == 16'h0001);
			end
		end

		// R4 R5 irq reload of the standby timer only when enabled
		if ((|act) || (irq_activity && s.standby_reload_on_irq))
		begin
			next_s.standby_cnt = s.standby_reload;
		end
		else if (tick && s.standby_cnt != 16'h0000)
		begin
			next_s.standby_cnt = s.standby_cnt - 16'h0001;
			standby_exp        = (s.standby_cnt == 16'h0001);
		end

		// R2 burst from enabled idle timers or external request
		burst = (|(idle_exp & s.burst_source_enable[NUM_DEV-1:0]))
			| (ext_burst & s.burst_source_enable[`BURST_EXT_BIT] & ~ext_disk_cycle);

		if (burst && s.cstate != stop_clock_pkg::FULL_SPEED)
		begin
			next_s.cstate = stop_clock_pkg::FULL_SPEED;
		end

		// R1 level reads applied after the burst so entry is never lost
		if (accept && read && address == `REG_LEVEL_TWO)
		begin
			next_s.cstate = stop_clock_pkg::LEVEL_TWO;
		end
		if (accept && read && address == `REG_LEVEL_THREE)
		begin
			next_s.cstate = stop_clock_pkg::LEVEL_THREE;
		end

		// R9 R12 two-second qualification of the thermal input
		next_s.hot_q = hot;
		if (!hot)
		begin
			next_s.therm_cnt = '0;
			next_s.therm_ovr = 1'b0;
		end
		else if (s.therm_cnt != THERM_W'(THERM_DELAY_CYCLES))
		begin
			next_s.therm_cnt = s.therm_cnt + THERM_W'(1);
		end
		else
		begin
			next_s.therm_ovr = 1'b1;
		end

		if (s.slot_cnt == SW'(MIN_HIGH_CYCLES - 1))
		begin
			next_s.slot_cnt = '0;
			next_s.phase    = s.phase + 3'h1;
		end
		else
		begin
			next_s.slot_cnt = s.slot_cnt + SW'(1);
		end

		if (accept && write)
		begin
			unique case (address)
				`REG_PROC_CTL:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.throttle_duty_field = wv[2:0];
					next_s.throttle_en         = wv[4];
				end
				`REG_COUNT_B:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.overheat_duty_field = wv[2:0];
				end
				`REG_GLOBAL_CTL:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.overheat_irq_enable      = wv[0];
					next_s.control_irq_route_enable = wv[1];
					next_s.standby_reload_on_irq    = wv[2];
				end
				`REG_IDLE_CTL:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.idle_en     = wv[NUM_DEV-1:0];
					next_s.idle_reload = wv[31:16];
				end
				`REG_BURST_SRC:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.burst_source_enable = wv[NUM_DEV:0];
				end
				`REG_STANDBY_RELOAD:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.standby_reload = wv[15:0];
				end
				`REG_MASK:
				begin
					wv = merge(reg_value(s, address), writedata, byteenable);
					next_s.mask = wv[`FLAG_WIDTH-1:0];
				end
				default:
				begin
					wv = 32'h0000_0000;
				end
			endcase
		end

		// R14 read clears only bits already reported; new events win
		if (accept && read && address == `REG_STATUS)
		begin
			next_s.flags = s.flags & ~s.readdata[`FLAG_WIDTH-1:0];
		end
		next_s.flags[`FLAG_OVERHEAT] = next_s.flags[`FLAG_OVERHEAT] | (hot & ~s.hot_q);
		next_s.flags[`FLAG_IDLE_LSB +: NUM_DEV] = next_s.flags[`FLAG_IDLE_LSB +: NUM_DEV] | idle_exp;
		next_s.flags[`FLAG_STANDBY] = next_s.flags[`FLAG_STANDBY] | standby_exp;
		next_s.flags[`FLAG_BURST]   = next_s.flags[`FLAG_BURST] | burst;

		// R6 R7 R13 management interrupt for idle timeouts or enabled thermal with routing clear
		next_s.mgmt = (|s.flags[`FLAG_IDLE_LSB +: NUM_DEV])
			| (s.flags[`FLAG_OVERHEAT] & s.overheat_irq_enable & ~s.control_irq_route_enable);
		// R8 R13 thermal routed to control interrupt
		next_s.ctl_irq = s.flags[`FLAG_OVERHEAT] & s.overheat_irq_enable & s.control_irq_route_enable;
	end

	always_comb
	begin
		// R11 R12 override throttles whatever state was held before
		if (s.therm_ovr)
		begin
			want_halt = halted_slot(s.phase, s.overheat_duty_field);
		end
		else if (s.cstate != stop_clock_pkg::FULL_SPEED)
		begin
			want_halt = 1'b1;
		end
		else
		begin
			want_halt = s.throttle_en & halted_slot(s.phase, s.throttle_duty_field);
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s.cstate                   <= stop_clock_pkg::FULL_SPEED;
			s.ack                      <= 1'b0;
			s.readdata                 <= 32'h0000_0000;
			s.throttle_duty_field      <= `RESET_DUTY;
			s.throttle_en              <= 1'b0;
			s.overheat_duty_field      <= `RESET_DUTY;
			s.overheat_irq_enable      <= 1'b0;
			s.control_irq_route_enable <= 1'b0;
			s.standby_reload_on_irq    <= 1'b0;
			s.idle_en                  <= '0;
			s.idle_reload              <= `RESET_RELOAD;
			s.burst_source_enable      <= '0;
			s.standby_reload           <= `RESET_RELOAD;
			s.flags                    <= '0;
			s.mask                     <= '0;
			s.idle_cnt                 <= '0;
			s.standby_cnt              <= 16'h0000;
			s.tick_cnt                 <= '0;
			s.hot_q                    <= 1'b0;
			s.therm_cnt                <= '0;
			s.therm_ovr                <= 1'b0;
			s.slot_cnt                 <= '0;
			s.phase                    <= 3'h0;
			s.mgmt                     <= 1'b0;
			s.ctl_irq                  <= 1'b0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// R10 output stage enforces the least high time
	halt_shaper #(
		.MIN_HIGH_CYCLES (MIN_HIGH_CYCLES)
	) u_shaper (
		.clock            (clock),
		.sys_rst          (sys_rst),
		.want_halt        (want_halt),
		.cpu_clock_halt_n (cpu_clock_halt_n)
	);

	assign waitrequest = (read | write) & ~s.ack;
	assign readdata    = s.readdata;
	assign mgmt_irq_n  = ~s.mgmt;
	assign control_irq = s.ctl_irq;
	assign irq         = |(s.flags & s.mask);

endmodule : stop_clock_thermal_control

// file: dv/stop_clock_properties.sv
// concurrent checks on the ports of the clock-control block
`timescale 1ns/100ps
`include "stop_clock_regs.svh"

module stop_clock_properties (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [5:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic        waitrequest,
	input wire logic        overheat_in_n,
	input wire logic        cpu_clock_halt_n,
	input wire logic        mgmt_irq_n,
	input wire logic        control_irq,
	input wire logic        irq
);
	localparam int MIN_HIGH = `MIN_HIGH_NS * `CLOCK_MHZ / 1000;
	logic [1:0]  gctl;
	logic        mask0;
	logic [10:0] hi_cnt;
	logic        wr_ok;
	logic [10:0] lvl_cnt;
	logic        lvl_hit;

	assign wr_ok   = write && !waitrequest && byteenable[0];
	assign lvl_hit = read && !waitrequest && (address == `REG_LEVEL_TWO || address == `REG_LEVEL_THREE);

	// shadows of enables, and high-run length saturating at the minimum
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			gctl   <= 2'h0;
			mask0  <= 1'b0;
			hi_cnt <= 11'h500;
			lvl_cnt <= 11'h0;
		end
		else
		begin
			if (wr_ok && address == `REG_GLOBAL_CTL)
				gctl <= writedata[1:0];
			if (wr_ok && address == `REG_MASK)
				mask0 <= writedata[0];
			if (!cpu_clock_halt_n)
				hi_cnt <= 11'h0;
			else if (hi_cnt < 11'h500)
				hi_cnt <= hi_cnt + 11'h1;
			// cycles since an accepted level read with the stop-clock still high
			if (!cpu_clock_halt_n)
				lvl_cnt <= 11'h0;
			else if (lvl_cnt != 11'h0 && lvl_cnt != 11'h7ff)
				lvl_cnt <= lvl_cnt + 11'h1;
			else if (lvl_cnt == 11'h0 && lvl_hit)
				lvl_cnt <= 11'h1;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	property p_one_wait;
		$rose(read) || $rose(write) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait state");
	property p_level_entry;
		cpu_clock_halt_n |-> lvl_cnt < 11'h578;
	endproperty
	a_level_entry: assert property (p_level_entry) else $error("level read did not halt the clock");
	property p_therm_mgmt;
		$fell(overheat_in_n) && gctl == 2'h1 |-> ##[1:3] !mgmt_irq_n;
	endproperty
	a_therm_mgmt: assert property (p_therm_mgmt) else $error("no management interrupt on overheat");
	property p_therm_ctl;
		$fell(overheat_in_n) && gctl == 2'h3 |-> ##[1:3] control_irq;
	endproperty
	a_therm_ctl: assert property (p_therm_ctl) else $error("no control interrupt on overheat");
	property p_therm_off;
		$fell(overheat_in_n) && !gctl[0] && mgmt_irq_n && !control_irq |-> (mgmt_irq_n && !control_irq)[*4];
	endproperty
	a_therm_off: assert property (p_therm_off) else $error("overheat interrupt while disabled");
	property p_min_high;
		$fell(cpu_clock_halt_n) |-> hi_cnt >= MIN_HIGH;
	endproperty
	a_min_high: assert property (p_min_high) else $error("stop-clock high time too short");
	property p_flag_set;
		$fell(overheat_in_n) && mask0 |-> ##[1:3] irq;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("overheat flag not raised");
	property p_flag_sticky;
		irq && !(read && address == `REG_STATUS) && !(write && address == `REG_MASK) |=> irq;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("status dropped without a read");
endmodule : stop_clock_properties

// file: dv/cpu_halt_model.sv
// processor end: records the shortest high run of the stop-clock line
`timescale 1ns/100ps

module cpu_halt_model (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic cpu_clock_halt_n,
	output int        min_high
);
	int run;
	bit seen_low;

	// runs counted only between two halts
	always @(posedge clock)
	begin
		if (sys_rst)
		begin
			run = 0;
			seen_low = 0;
			min_high = 100000;
		end
		else if (cpu_clock_halt_n)
			run++;
		else
		begin
			if (seen_low && run > 0 && run < min_high)
				min_high = run;
			seen_low = 1;
			run = 0;
		end
	end
endmodule : cpu_halt_model

// file: dv/stop_clock_thermal_control_tb.sv
// self-checking bench for the clock-control block
`timescale 1ns/100ps
`include "stop_clock_regs.svh"

module stop_clock_thermal_control_tb;
	typedef struct packed {
		logic [5:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
	} row_t;
	localparam int DLY = 100;
	logic        clock, sys_rst, read, write, waitrequest, ext_disk_cycle, irq_activity, ext_burst;
	logic        overheat_in_n, cpu_clock_halt_n, mgmt_irq_n, control_irq, irq;
	logic [5:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0]  byteenable, dev_activity;
	int          min_high, num_errors, samples_checked, n;
	row_t        rows [6];
	logic [1:0]  cfg [3];

	stop_clock_thermal_control #(.THERM_DELAY_CYCLES(DLY)) stop_clock_thermal_control_inst (
		.clock(clock), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.dev_activity(dev_activity), .ext_disk_cycle(ext_disk_cycle), .irq_activity(irq_activity),
		.ext_burst(ext_burst), .overheat_in_n(overheat_in_n), .cpu_clock_halt_n(cpu_clock_halt_n),
		.mgmt_irq_n(mgmt_irq_n), .control_irq(control_irq), .irq(irq));
	cpu_halt_model cpu_halt_model_inst (.clock(clock), .sys_rst(sys_rst), .cpu_clock_halt_n(cpu_clock_halt_n),
		.min_high(min_high));

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// one access; an idle cycle follows so strobes never toggle twice in a step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		address <= a;
		writedata <= d;
		byteenable <= 4'hf;
		read <= !wr;
		write <= wr;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (waitrequest !== 1'b0 && k < 20);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		if (k >= 20)
		begin
			num_errors++;
			final_report();
		end
	endtask : bus

	task automatic wait_low(input bit sel, input int lim);
		int k;
		k = 0;
		while ((sel ? mgmt_irq_n : cpu_clock_halt_n) !== 1'b0 && k < lim)
		begin
			@(posedge clock);
			k++;
		end
		if (k >= lim)
		begin
			num_errors++;
			final_report();
		end
	endtask : wait_low

	task automatic pulse(input logic [3:0] act, input logic eb, input logic disk);
		dev_activity <= act;
		ext_burst <= eb;
		ext_disk_cycle <= disk;
		@(posedge clock);
		dev_activity <= 4'h0;
		ext_burst <= 1'b0;
		ext_disk_cycle <= 1'b0;
		@(posedge clock);
	endtask : pulse

	task automatic count_low(input int len, output int lows);
		lows = 0;
		repeat (len)
		begin
			@(negedge clock);
			if (cpu_clock_halt_n === 1'b0)
				lows++;
		end
		@(posedge clock);
	endtask : count_low

	initial
	begin
		rows = '{'{`REG_PROC_CTL, 32'h7, 32'h7}, '{`REG_COUNT_B, 32'h7, 32'h7}, '{`REG_STANDBY_RELOAD, 32'h1234, 32'h1234},
			'{`REG_MASK, 32'h7f, 32'h7f}, '{`REG_CLOCK_STATE, 32'h3, 32'h0}, '{6'h3c, 32'hffffffff, 32'h0}};
		cfg = '{2'h0, 2'h1, 2'h3};
		num_errors = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		overheat_in_n = 1'b1;
		{address, read, write, writedata, byteenable, dev_activity, ext_disk_cycle, irq_activity, ext_burst} = '0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		check("outputs", {cpu_clock_halt_n, mgmt_irq_n, control_irq, irq}, 4'hc);
		$display("reset test done");
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].addr, rows[i].wdata, rd);
			bus(1'b0, rows[i].addr, 32'h0, rd);
			check("readback", rd, rows[i].rdata);
		end
		$display("register table done");
		// only device 3 as burst source, external bursts off
		bus(1'b1, `REG_BURST_SRC, 32'h8, rd);
		bus(1'b1, `REG_IDLE_CTL, 32'h0003_0008, rd);
		for (int m = 1; m <= 2; m++)
		begin
			bus(1'b0, m == 1 ? `REG_LEVEL_TWO : `REG_LEVEL_THREE, 32'h0, rd);
			wait_low(1'b0, 1400);
			bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
			check("clock_state", rd, m);
			pulse(4'h8, 1'b0, 1'b1);
			repeat (300) @(posedge clock);
			check("mgmt_irq_n", mgmt_irq_n, 1'b1);
			pulse(4'h8, 1'b0, 1'b0);
			wait_low(1'b1, 400);
			bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
			check("clock_state", rd, 32'h0);
			bus(1'b0, `REG_STATUS, 32'h0, rd);
			check("status", rd, 32'h50);
		end
		$display("level and burst test done");
		foreach (cfg[i])
		begin
			bus(1'b1, `REG_GLOBAL_CTL, {30'h0, cfg[i]}, rd);
			overheat_in_n <= 1'b0;
			repeat (6) @(posedge clock);
			check("mgmt_irq_n", mgmt_irq_n, cfg[i] != 2'h1);
			check("control_irq", control_irq, cfg[i] == 2'h3);
			check("irq", irq, 1'b1);
			overheat_in_n <= 1'b1;
			repeat (6) @(posedge clock);
			bus(1'b0, `REG_STATUS, 32'h0, rd);
			check("status", rd, 32'h1);
			repeat (3) @(posedge clock);
			check("irq_lines", {mgmt_irq_n, control_irq, irq}, 3'h4);
		end
		$display("overheat interrupt test done");
		bus(1'b1, `REG_GLOBAL_CTL, 32'h0, rd);
		overheat_in_n <= 1'b0;
		count_low(DLY - 5, n);
		check("early_halt", n, 32'h0);
		repeat (10240) @(posedge clock);
		count_low(10240, n);
		check("duty_seven", n >= 8950 && n <= 8960, 1'b1);
		bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
		check("override", rd, 32'h4);
		overheat_in_n <= 1'b1;
		repeat (2000) @(posedge clock);
		bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
		check("restored", {rd[2:0], cpu_clock_halt_n}, 4'h1);
		bus(1'b1, `REG_PROC_CTL, 32'h17, rd);
		repeat (10240) @(posedge clock);
		count_low(10240, n);
		check("throttle_seven", n >= 8950 && n <= 8960, 1'b1);
		bus(1'b1, `REG_PROC_CTL, 32'h0, rd);
		check("min_high", min_high >= 1280, 1'b1);
		$display("throttle test done");
		// firmware lets interrupt activity reload the standby timer
		bus(1'b1, `REG_STANDBY_RELOAD, 32'h3, rd);
		for (int e = 1; e >= 0; e--)
		begin
			bus(1'b1, `REG_GLOBAL_CTL, e ? 32'h4 : 32'h0, rd);
			irq_activity <= 1'b1;
			@(posedge clock);
			irq_activity <= 1'b0;
			repeat (200) @(posedge clock);
			bus(1'b0, `REG_STATUS, 32'h0, rd);
			check("standby", rd, e ? 32'h21 : 32'h0);
		end
		// external burst leaves level two unless it rides a disk cycle
		bus(1'b1, `REG_BURST_SRC, 32'h10, rd);
		bus(1'b0, `REG_LEVEL_TWO, 32'h0, rd);
		wait_low(1'b0, 1400);
		pulse(4'h0, 1'b1, 1'b1);
		bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
		check("clock_state", rd, 32'h1);
		pulse(4'h0, 1'b1, 1'b0);
		bus(1'b0, `REG_CLOCK_STATE, 32'h0, rd);
		check("clock_state", rd, 32'h0);
		bus(1'b0, `REG_STATUS, 32'h0, rd);
		check("status", rd, 32'h40);
		$display("reload and external burst test done");
		final_report();
	end
endmodule : stop_clock_thermal_control_tb

bind stop_clock_thermal_control stop_clock_properties stop_clock_properties_inst (.clock(clock), .sys_rst(sys_rst),
	.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
	.waitrequest(waitrequest), .overheat_in_n(overheat_in_n), .cpu_clock_halt_n(cpu_clock_halt_n),
	.mgmt_irq_n(mgmt_irq_n), .control_irq(control_irq), .irq(irq));
